// File: dso_defines.svh
// register map, field layout and reset values of the dma status observer
// Operation
// R1: The high address word shows address bits 23 to 16 in its bits 7 to 0, read-only, zero after reset.
// R2: Bits 15 to 8 of the high address word read as zero and hold nothing.
// R3: The low address word shows address bits 15 to 0, read-only, zero after reset.
// R4: The collision word holds one read-only flag per channel at bit n for channels 0 to 3, bits 15 to 4 read zero.
// R5: A channel flag reads 1 once a write collision was seen on that channel and 0 otherwise, zero after reset; the code clears it via the clear word.
// R6: The address is captured on every engine RAM access and a flag sets when a channel write meets a competing write.
`ifndef DSO_DEFINES_SVH
`define DSO_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define DSO_OFF_ADDR_HIGH 12'h000
`define DSO_OFF_ADDR_LOW 12'h004
`define DSO_OFF_COLL_STATUS 12'h008
`define DSO_OFF_COLL_CLEAR 12'h00C
`define DSO_OFF_IRQ_ENABLE 12'h010
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DSO_ADDR_W 24
`define DSO_NUM_CH 4
`define DSO_ADDR_RESET 24'h000000
`define DSO_FLAG_RESET 4'h0
`endif

// File: dso_pkg.sv
// types shared by the dma status observer modules
package dso_pkg;
    typedef logic [23:0] dso_addr_t;
    typedef logic [3:0] dso_flags_t;
endpackage : dso_pkg

// File: dso_evt_if.sv
// event carrier between collision detector and status register
`timescale 1ns/10ps
`default_nettype none
interface dso_evt_if;
    logic [3:0] coll;
    modport src (output coll);
    modport dst (input coll);
endinterface : dso_evt_if
`default_nettype wire

// File: dso_coll_detect.sv
// per-channel peripheral write collision detector
`timescale 1ns/10ps
`default_nettype none
module dso_coll_detect
    import dso_pkg::*;
#(
    parameter int NUM_CH = 4
)(
    // channel write requests
    input wire logic [NUM_CH-1:0] ch_wr_i,
    input wire logic [NUM_CH-1:0] comp_wr_i,
    // event out
    dso_evt_if.src evt
);
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            // R6: coincident writes collide
            assign evt.coll[g] = ch_wr_i[g] & comp_wr_i[g];
        end
    endgenerate
endmodule : dso_coll_detect
`default_nettype wire

// File: dso_top.sv
// dma status observer top with apb register file and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "dso_defines.svh"
module dso_top
    import dso_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // dma engine observation
    input wire logic ram_acc_i,
    input wire logic [23:0] ram_addr_i,
    input wire logic [3:0] ch_wr_i,
    input wire logic [3:0] comp_wr_i,
    // interrupt
    output logic irq_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    dso_addr_t addr_q;
    dso_flags_t flag_q;
    dso_flags_t en_q;
    dso_evt_if evt_bus ();
    logic acc;
    logic clr_wr;

    dso_coll_detect #(.NUM_CH(`DSO_NUM_CH)) u_det (
        .ch_wr_i(ch_wr_i),
        .comp_wr_i(comp_wr_i),
        .evt(evt_bus)
    );

    // access phase: single wait-free answer
    assign acc = psel_i & penable_i;
    assign clr_wr = acc & pwrite_i & (paddr_i == `DSO_OFF_COLL_CLEAR);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one list of mapped words keeps the error and the checks in step
    function automatic logic is_mapped(input logic [11:0] addr);
        logic hit;
        hit = (addr == `DSO_OFF_ADDR_HIGH) | (addr == `DSO_OFF_ADDR_LOW) | (addr == `DSO_OFF_COLL_STATUS) |
            (addr == `DSO_OFF_COLL_CLEAR) | (addr == `DSO_OFF_IRQ_ENABLE);
        return hit;
    endfunction : is_mapped

    // R6: capture every access
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            addr_q <= `DSO_ADDR_RESET;
        else if (ram_acc_i)
            addr_q <= ram_addr_i;
    end

    // R5: sticky, set wins over clear
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flag_q <= `DSO_FLAG_RESET;
        else
            flag_q <= (flag_q & ~(clr_wr ? pwdata_i[3:0] : 4'h0)) | evt_bus.coll;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            en_q <= `DSO_FLAG_RESET;
        else if (acc & pwrite_i & (paddr_i == `DSO_OFF_IRQ_ENABLE))
            en_q <= pwdata_i[3:0];
    end

    // ----------------------------------------
    // apb read path
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            // ready in the first access cycle, dropped after
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h00000000;
            if (psel_i & ~penable_i & ~pwrite_i)
            begin
                unique case (paddr_i)
                    // R1: high byte, R2: upper bits zero
                    `DSO_OFF_ADDR_HIGH: prdata_o <= {24'h000000, addr_q[23:16]};
                    // R3: low sixteen bits
                    `DSO_OFF_ADDR_LOW: prdata_o <= {16'h0000, addr_q[15:0]};
                    // R4: flags in bits 3..0
                    `DSO_OFF_COLL_STATUS: prdata_o <= {28'h0000000, flag_q};
                    `DSO_OFF_IRQ_ENABLE: prdata_o <= {28'h0000000, en_q};
                    default: prdata_o <= 32'h00000000;
                endcase
            end
            if (psel_i & ~penable_i)
                pslverr_o <= ~is_mapped(paddr_i);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(flag_q & en_q);
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_addr_cap;
        @(posedge clk_i) disable iff (!resetn_i)
        ram_acc_i |=> addr_q == $past(ram_addr_i);
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("address not captured"); // R6

    property p_high_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_ADDR_HIGH && !ram_acc_i)
            |=> prdata_o == {24'h000000, addr_q[23:16]};
    endproperty
    a_high_read: assert property (p_high_read) else $error("high read wrong"); // R1

    property p_high_zero;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && paddr_i == `DSO_OFF_ADDR_HIGH) |=> prdata_o[31:8] == 24'h000000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high upper bits set"); // R2

    property p_low_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_ADDR_LOW && !ram_acc_i)
            |=> prdata_o == {16'h0000, addr_q[15:0]};
    endproperty
    a_low_read: assert property (p_low_read) else $error("low read wrong"); // R3

    property p_coll_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && paddr_i == `DSO_OFF_COLL_STATUS) |=> prdata_o[31:4] == 28'h0000000;
    endproperty
    a_coll_read: assert property (p_coll_read) else $error("collision upper bits set"); // R4

    property p_flag_set;
        @(posedge clk_i) disable iff (!resetn_i)
        (ch_wr_i[0] && comp_wr_i[0]) |=> flag_q[0] ##1 irq_o == en_q[0] || $past(en_q[0]) != en_q[0] || irq_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // R5

    property p_flag_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        (!clr_wr && flag_q != 4'h0) |=> (flag_q & $past(flag_q)) == $past(flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without clear"); // R5

    property p_ready_one;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i) |=> pready_o ##1 !pready_o;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready not one cycle"); // apb handshake

    // only an engine access may move the captured address
    property p_addr_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !ram_acc_i |=> $stable(addr_q);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved without access"); // R6

    // read data is the word as it stood at the setup edge
    property p_high_live;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_ADDR_HIGH)
            |=> prdata_o[7:0] == $past(addr_q[23:16]);
    endproperty
    a_high_live: assert property (p_high_live) else $error("high byte not the captured one"); // R1

    property p_low_live;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_ADDR_LOW)
            |=> prdata_o[15:0] == $past(addr_q[15:0]);
    endproperty
    a_low_live: assert property (p_low_live) else $error("low half not the captured one"); // R3

    property p_low_zero;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && paddr_i == `DSO_OFF_ADDR_LOW) |=> prdata_o[31:16] == 16'h0000;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low upper bits set"); // R3

    property p_coll_flags;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_COLL_STATUS)
            |=> prdata_o[3:0] == $past(flag_q);
    endproperty
    a_coll_flags: assert property (p_coll_flags) else $error("collision flags read wrong"); // R4

    property p_clr_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && paddr_i == `DSO_OFF_COLL_CLEAR) |=> prdata_o == 32'h00000000;
    endproperty
    a_clr_read: assert property (p_clr_read) else $error("clear word read not zero");

    property p_irq_quiet;
        @(posedge clk_i) disable iff (!resetn_i)
        ((flag_q & en_q) == 4'h0) |=> !irq_o;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled flag"); // R5

    property p_irq_high;
        @(posedge clk_i) disable iff (!resetn_i)
        irq_o |-> $past((flag_q & en_q) != 4'h0);
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("interrupt without cause"); // R5

    property p_err_unmapped;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !is_mapped(paddr_i)) |=> pslverr_o && pready_o;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");

    property p_err_mapped;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && is_mapped(paddr_i)) |=> !pslverr_o;
    endproperty
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");

    property p_err_ready;
        @(posedge clk_i) disable iff (!resetn_i)
        pslverr_o |-> pready_o;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    property p_ready_idle;
        @(posedge clk_i) disable iff (!resetn_i)
        !(psel_i && !penable_i) |=> !pready_o;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready without setup");

    property p_rdata_idle;
        @(posedge clk_i) disable iff (!resetn_i)
        !(psel_i && !penable_i && !pwrite_i) |=> prdata_o == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a read");

    property p_en_write;
        @(posedge clk_i) disable iff (!resetn_i)
        (acc && pwrite_i && paddr_i == `DSO_OFF_IRQ_ENABLE) |=> en_q == $past(pwdata_i[3:0]);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable write lost");

    property p_en_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !(acc && pwrite_i && paddr_i == `DSO_OFF_IRQ_ENABLE) |=> $stable(en_q);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved without write");

    property p_en_read;
        @(posedge clk_i) disable iff (!resetn_i)
        (psel_i && !penable_i && !pwrite_i && paddr_i == `DSO_OFF_IRQ_ENABLE)
            |=> prdata_o == {28'h0000000, $past(en_q)};
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable read wrong");

    // ----------------------------------------
    // per channel flag checks
    // ----------------------------------------
    // every channel checked, not only the first
    genvar c;
    generate
        for (c = 0; c < `DSO_NUM_CH; c++)
        begin : g_flag_chk
            property p_ch_set;
                @(posedge clk_i) disable iff (!resetn_i)
                (ch_wr_i[c] && comp_wr_i[c]) |=> flag_q[c];
            endproperty
            a_ch_set: assert property (p_ch_set) else $error("channel flag not set"); // R6

            property p_ch_clear;
                @(posedge clk_i) disable iff (!resetn_i)
                (clr_wr && pwdata_i[c] && !(ch_wr_i[c] && comp_wr_i[c])) |=> !flag_q[c];
            endproperty
            a_ch_clear: assert property (p_ch_clear) else $error("channel flag not cleared"); // R5

            property p_ch_idle;
                @(posedge clk_i) disable iff (!resetn_i)
                (!flag_q[c] && !(ch_wr_i[c] && comp_wr_i[c])) |=> !flag_q[c];
            endproperty
            a_ch_idle: assert property (p_ch_idle) else $error("channel flag set without collision"); // R5

            property p_ch_irq;
                @(posedge clk_i) disable iff (!resetn_i)
                (flag_q[c] && en_q[c]) |=> irq_o;
            endproperty
            a_ch_irq: assert property (p_ch_irq) else $error("enabled flag gave no interrupt"); // R5
        end
    endgenerate
endmodule : dso_top
`default_nettype wire

// File: dma_status_observer_tb_top.sv
// self-checking bench of the dma status observer
`timescale 1ns/10ps
`default_nettype none
`include "dso_defines.svh"
module dma_status_observer_tb_top import dso_pkg::*; ;
    logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, ram_acc_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, irq_o, err;
    dso_addr_t ram_addr_i;
    dso_flags_t ch_wr_i, comp_wr_i;
    int n_mismatch = 0;
    int checks = 0;
    dso_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .ram_acc_i(ram_acc_i), .ram_addr_i(ram_addr_i), .ch_wr_i(ch_wr_i), .comp_wr_i(comp_wr_i), .irq_o(irq_o));
    // ----
    // bus and compare tasks
    // ----
    task automatic report_and_stop;
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until pready seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_i);
        psel_i <= 1'h1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'h1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            if (pready_o === 1'h1)
                break;
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        if (i == 16)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    // address moves away after the access so a stray capture shows
    task automatic acc(input dso_addr_t a);
        @(posedge clk_i);
        ram_acc_i <= 1'h1;
        ram_addr_i <= a;
        @(posedge clk_i);
        ram_acc_i <= 1'h0;
        ram_addr_i <= ~a;
    endtask : acc
    task automatic ev(input dso_flags_t ch, input dso_flags_t comp);
        @(posedge clk_i);
        ch_wr_i <= ch;
        comp_wr_i <= comp;
        @(posedge clk_i);
        ch_wr_i <= 4'h0;
        comp_wr_i <= 4'h0;
    endtask : ev
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        chk({31'h0, irq_o}, {31'h0, exp});
    endtask : irq_is
    // ----
    // scenarios
    // ----
    task automatic t_reset;
        rdchk(`DSO_OFF_ADDR_HIGH, 32'h0);
        rdchk(`DSO_OFF_ADDR_LOW, 32'h0);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h0);
    endtask : t_reset
    task automatic t_addr;
        acc(24'h123456);
        acc(24'hA5C3E1);
        rdchk(`DSO_OFF_ADDR_HIGH, 32'h000000A5);
        rdchk(`DSO_OFF_ADDR_LOW, 32'h0000C3E1);
        apb(1'h1, `DSO_OFF_ADDR_HIGH, 32'hFFFFFFFF);
        apb(1'h1, `DSO_OFF_ADDR_LOW, 32'hFFFFFFFF);
        rdchk(`DSO_OFF_ADDR_HIGH, 32'h000000A5);
        rdchk(`DSO_OFF_ADDR_LOW, 32'h0000C3E1);
    endtask : t_addr
    task automatic t_coll;
        ev(4'h4, 4'h0);
        ev(4'h2, 4'h4);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h0);
        ev(4'h9, 4'h9);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h00000009);
        apb(1'h1, `DSO_OFF_COLL_STATUS, 32'hFFFFFFFF);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h00000009);
    endtask : t_coll
    task automatic t_irq;
        apb(1'h1, `DSO_OFF_IRQ_ENABLE, 32'h00000004);
        irq_is(1'h0);
        apb(1'h1, `DSO_OFF_IRQ_ENABLE, 32'h00000008);
        irq_is(1'h1);
        apb(1'h1, `DSO_OFF_COLL_CLEAR, 32'h00000008);
        irq_is(1'h0);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h00000001);
        apb(1'h1, `DSO_OFF_COLL_CLEAR, 32'hFFFFFFFF);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h0);
        rdchk(12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_irq
    // event held across the clear so both meet on the access edge
    task automatic t_race;
        @(posedge clk_i);
        ch_wr_i <= 4'h2;
        comp_wr_i <= 4'h2;
        apb(1'h1, `DSO_OFF_COLL_CLEAR, 32'h00000002);
        ch_wr_i <= 4'h0;
        comp_wr_i <= 4'h0;
        rdchk(`DSO_OFF_COLL_STATUS, 32'h00000002);
        ev(4'h4, 4'h4);
        rdchk(`DSO_OFF_COLL_STATUS, 32'h00000006);
        rdchk(`DSO_OFF_IRQ_ENABLE, 32'h00000008);
        irq_is(1'h0);
        apb(1'h1, `DSO_OFF_IRQ_ENABLE, 32'h00000004);
        irq_is(1'h1);
    endtask : t_race
    // reset in mid-run must wipe address, flags, enable and interrupt
    task automatic t_rst2;
        acc(24'h7E8D9C);
        @(posedge clk_i);
        resetn_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'h1;
        irq_is(1'h0);
        t_reset();
        rdchk(`DSO_OFF_IRQ_ENABLE, 32'h0);
    endtask : t_rst2
    initial
    begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        {resetn_i, psel_i, penable_i, pwrite_i, ram_acc_i} = 5'h0;
        paddr_i = 12'h0;
        pwdata_i = 32'h0;
        ram_addr_i = 24'h0;
        ch_wr_i = 4'h0;
        comp_wr_i = 4'h0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'h1;
        t_reset();
        t_addr();
        t_coll();
        t_irq();
        t_race();
        t_rst2();
        report_and_stop();
    end
endmodule : dma_status_observer_tb_top
`default_nettype wire
